// ==== pca_cc_sva.sv ====
// Checker of the counter array control block ports
module pca_cc_sva
  import pca_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_rdata,
  input wire logic [4:0] module_event,
  input wire logic [4:0] module_irq_enable,
  input wire logic [15:0] count_value,
  input wire logic count_tick,
  input wire logic wdog_enable_m4,
  input wire logic prog_counter_array_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire ctl = sfr_addr == CTRL_ADDR;
  sequence run_off; ctl && !sfr_rdata[RUN_BIT]; endsequence
  sequence step; !$past(srst) && $changed(count_value); endsequence
  step_inc_a: assert property (
    step |-> count_value == $past(count_value) + 16'h1) else $error("step");
  tick_a: assert property (
    step |-> count_tick) else $error("tick");
  run_off_a: assert property (
    run_off [*3] |-> $stable(count_value)) else $error("run");
  wdog_a: assert property (
    sfr_wr && sfr_addr == MODE_ADDR |=>
    wdog_enable_m4 == $past(sfr_wdata[WDOG_EN_BIT])) else $error("wdog");
  flag_set_a: assert property (
    module_event != 5'h00 ##1 ctl |->
    (sfr_rdata[4:0] & $past(module_event)) == $past(module_event))
    else $error("flag set");
  flag_hold_a: assert property (
    ctl && !sfr_wr ##1 ctl |-> (sfr_rdata & $past(sfr_rdata) & 8'h9F)
    == ($past(sfr_rdata) & 8'h9F)) else $error("flag hold");
  ovf_wrap_a: assert property (
    !$past(srst) && $past(count_value) == 16'hFFFF && count_value == 16'h0
    && ctl |-> sfr_rdata[OVF_BIT]) else $error("wrap");
  irq_ev_a: assert property (
    (module_event & module_irq_enable) != 5'h00 ##1
    $stable(module_irq_enable) |-> prog_counter_array_irq) else $error("irq");
endmodule
bind pca_counter_control pca_cc_sva u_sva (.clk, .srst, .sfr_addr,
  .sfr_wdata, .sfr_wr, .sfr_rdata, .module_event, .module_irq_enable,
  .count_value, .count_tick, .wdog_enable_m4, .prog_counter_array_irq);

// ==== pca_counter_control.sv ====
// Time base, run control, flags and interrupt of the counter array
module pca_counter_control
  import pca_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  output logic [7:0] sfr_rdata,
  input wire logic cpu_idle,
  input wire logic double_speed_mode,
  input wire logic timer0_overflow,
  input wire logic ext_count_input,
  input wire logic [4:0] module_event,
  input wire logic [4:0] module_irq_enable,
  output logic [15:0] count_value,
  output logic count_tick,
  output logic wdog_enable_m4,
  output logic prog_counter_array_irq
);
  // Register file
  logic [7:0] array_counter_control;
  logic [7:0] array_counter_mode;
  logic [7:0] next_control;
  logic [7:0] next_mode;
  logic ctrl_wr;
  logic mode_wr;

  // Time base
  logic [15:0] counter;
  logic [15:0] next_counter;
  logic next_count_tick;
  logic wrap;

  // External count pin
  logic ext_sync1;
  logic ext_sync2;
  logic ext_prev;
  logic next_ext_sync1;
  logic next_ext_sync2;
  logic next_ext_prev;
  logic ext_fall;

  // Count source selection and gating
  count_src_t src;
  logic [3:0] divide;
  logic div_run;
  logic div_tick;
  logic step;
  logic gated;

  // Interrupt sources
  logic [4:0] flag_set;
  logic [4:0] flag_irq;
  logic ovf_irq;

  // Write strobes of the two registers
  assign ctrl_wr = sfr_wr && (sfr_addr == CTRL_ADDR);
  assign mode_wr = sfr_wr && (sfr_addr == MODE_ADDR);
  // Count source from the two select bits of the mode register
  assign src = count_src_t'({array_counter_mode[SRC_HI_BIT],
                             array_counter_mode[SRC_LO_BIT]});
  // Counting stops when run is low or idle gating applies
  assign gated = !array_counter_control[RUN_BIT] ||
    (cpu_idle && array_counter_mode[IDLE_GATE_BIT]);

  // Division ratio of the internal sources; double speed halves it
  always_comb begin
    divide = DIV_12;
    case (src)
      SRC_OSC_SLOW: divide = double_speed_mode ? DIV_6 : DIV_12;
      SRC_OSC_FAST: divide = double_speed_mode ? DIV_2 : DIV_4;
      default: divide = DIV_12;
    endcase
  end

  // The divider rests for the timer and external sources, so a later
  // switch back to an internal source starts with a full period
  assign div_run = !gated && !src[1];

  pca_prescaler u_prescaler (
    .clk(clk),
    .srst(srst),
    .run(div_run),
    .divide(divide),
    .tick(div_tick)
  );

  // One step per count event of the selected source
  always_comb begin
    step = 1'b0;
    case (src)
      SRC_OSC_SLOW: step = div_tick;
      SRC_OSC_FAST: step = div_tick;
      SRC_TIMER0: step = timer0_overflow;
      SRC_EXT: step = ext_fall;
      default: step = 1'b0;
    endcase
    if (gated) begin
      step = 1'b0;
    end
  end

  // Rollover happens on the step taken from all ones
  assign wrap = step && (counter == 16'hFFFF);

  // Software writes first and hardware sets after them, so that an
  // event in the cycle of a clearing write is not lost
  always_comb begin
    next_control = array_counter_control;
    next_mode = array_counter_mode;
    if (mode_wr) begin
      // Reserved bits are not stored and read back as zero
      next_mode = sfr_wdata & 8'hC7;
    end
    if (ctrl_wr) begin
      // Software may set or clear flags and the run bit
      next_control = sfr_wdata & 8'hDF;
    end
    // Only a write lowers a flag; hardware only ever sets them
    if (wrap) begin
      next_control[OVF_BIT] = 1'b1;
    end
    next_control[4:0] = next_control[4:0] | flag_set;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      array_counter_control <= CTRL_RESET;
      array_counter_mode <= MODE_RESET;
    end else begin
      array_counter_control <= next_control;
      array_counter_mode <= next_mode;
    end
  end

  // Time base shared by all modules; the tick marks each step
  always_comb begin
    next_counter = counter;
    next_count_tick = step;
    if (step) begin
      next_counter = counter + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      counter <= 16'h0000;
      count_tick <= 1'b0;
    end else begin
      counter <= next_counter;
      count_tick <= next_count_tick;
    end
  end

  // Two flops bring the pin into the clock domain; the third holds the
  // previous synchronised level so each falling edge counts once
  always_comb begin
    next_ext_sync1 = ext_count_input;
    next_ext_sync2 = ext_sync1;
    next_ext_prev = ext_sync2;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_sync1 <= next_ext_sync1;
      ext_sync2 <= next_ext_sync2;
      ext_prev <= next_ext_prev;
    end
  end

  // Resetting low makes a high pin after reset a rise, never a fall
  assign ext_fall = ext_prev && !ext_sync2;

  // Per-module flag set and interrupt request
  for (genvar m = 0; m < NUM_MODULES; m++) begin : g_module
    assign flag_set[m] = module_event[m];
    assign flag_irq[m] =
      array_counter_control[m] && module_irq_enable[m];
  end

  assign ovf_irq = array_counter_control[OVF_BIT] &&
    array_counter_mode[OVF_IE_BIT];
  // Overflow and all module flags share one request line
  assign prog_counter_array_irq = ovf_irq || (|flag_irq);

  // Register read; unmapped addresses return zero
  // Reads are combinational, so a write shows on the following cycle
  always_comb begin
    sfr_rdata = 8'h00;
    if (sfr_addr == CTRL_ADDR) begin
      sfr_rdata = array_counter_control;
    end else if (sfr_addr == MODE_ADDR) begin
      sfr_rdata = array_counter_mode;
    end
  end

  // Common time base for capture, timer, fast output and PWM functions
  assign count_value = counter;
  // Modules 0 to 3 get no watchdog enable; only module 4 does
  assign wdog_enable_m4 = array_counter_mode[WDOG_EN_BIT];
endmodule

// ==== pca_pkg.sv ====
// Package of constants for the counter array control block
package pca_pkg;
  localparam logic [7:0] CTRL_ADDR = 8'hD8;
  localparam logic [7:0] MODE_ADDR = 8'hD9;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // Control register fields
  localparam int OVF_BIT = 7;
  localparam int RUN_BIT = 6;
  localparam int NUM_MODULES = 5;
  // Mode register fields
  localparam int IDLE_GATE_BIT = 7;
  localparam int WDOG_EN_BIT = 6;
  localparam int SRC_HI_BIT = 2;
  localparam int SRC_LO_BIT = 1;
  localparam int OVF_IE_BIT = 0;
  // Prescale counts
  localparam logic [3:0] DIV_12 = 4'hC;
  localparam logic [3:0] DIV_6 = 4'h6;
  localparam logic [3:0] DIV_4 = 4'h4;
  localparam logic [3:0] DIV_2 = 4'h2;
  typedef enum logic [1:0] {
    SRC_OSC_SLOW = 2'b00,
    SRC_OSC_FAST = 2'b01,
    SRC_TIMER0 = 2'b10,
    SRC_EXT = 2'b11
  } count_src_t;
endpackage

// ==== pca_prescaler.sv ====
// Divider that makes the one-cycle count enable from the oscillator clock
module pca_prescaler
  import pca_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [3:0] divide,
  output logic tick
);
  logic [3:0] count;
  logic [3:0] next_count;

  always_comb begin
    next_count = count;
    tick = 1'b0;
    if (!run) begin
      next_count = 4'h0;
    end else if (count >= divide - 4'h1) begin
      next_count = 4'h0;
      tick = 1'b1;
    end else begin
      next_count = count + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count <= 4'h0;
    end else begin
      count <= next_count;
    end
  end
endmodule

// ==== tb.sv ====
// Self-checking bench of the counter array control block
module tb
  import pca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, sfr_wr = 0, cpu_idle = 0, dsm = 0, t0 = 0, xin = 1;
  logic [7:0] addr = 8'hD8, wd = 8'h00;
  logic [4:0] ev = 5'h00, en = 5'h00;
  logic [31:0] s = 32'h555E, r;
  logic [15:0] c0;
  wire [7:0] rd;
  wire [15:0] cnt;
  wire tick, wdog, irq;
  int failures = 0, n_compared = 0, i, k, c;
  always #5 clk = ~clk;
  pca_counter_control u_dut (.clk, .srst, .sfr_addr(addr), .sfr_wdata(wd),
    .sfr_wr, .sfr_rdata(rd), .cpu_idle, .double_speed_mode(dsm),
    .timer0_overflow(t0), .ext_count_input(xin), .module_event(ev),
    .module_irq_enable(en), .count_value(cnt), .count_tick(tick),
    .wdog_enable_m4(wdog), .prog_counter_array_irq(irq));
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic int per(logic f, logic d);
    return f ? (d ? 2 : 4) : (d ? 6 : 12);
  endfunction
  task automatic end_sim();
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk) {addr, wd, sfr_wr} = {a, d, 1'b1};
    @(negedge clk) {addr, sfr_wr} = {CTRL_ADDR, 1'b0};
  endtask
  task automatic rdk(string n, logic [7:0] a, logic [7:0] exp);
    @(negedge clk) addr = a;
    #1 chk(n, rd, exp);
  endtask
  task automatic wt(output int n);
    n = 0;
    do @(negedge clk) n++; while (tick !== 1'b1 && n < 200);
    if (n >= 200) begin
      failures++;
      end_sim();
    end
  endtask
  task automatic pulse();
    @(negedge clk) t0 = 1;
    @(negedge clk) t0 = 0;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    srst = 0;
    rdk("ctrl", CTRL_ADDR, 8'h00);
    rdk("mode", MODE_ADDR, 8'h00);
    rdk("free", 8'hD7, 8'h00);
    for (i = 0; i < 4; i++) begin
      r = rnd() & 32'hC7;
      wr(MODE_ADDR, r[7:0]);
      rdk("mode rb", MODE_ADDR, r[7:0]);
      chk("wdog", wdog, r[6]);
    end
    for (i = 0; i < 4; i++) begin
      dsm = i[1];
      wr(MODE_ADDR, {6'h0, i[0], 1'b0});
      wr(CTRL_ADDR, 8'h40);
      wt(c);
      wt(c);
      chk("period", c, per(i[0], i[1]));
    end
    for (i = 0; i < 3; i++) begin
      wr(MODE_ADDR, {i[0], 7'h02});
      wr(CTRL_ADDR, {1'b0, i < 2, 6'h0});
      cpu_idle = i[1] ? 0 : 1;
      c0 = cnt;
      repeat (30) @(negedge clk);
      chk("gate", cnt !== c0, i == 0);
    end
    for (i = 2; i < 4; i++) begin
      wr(MODE_ADDR, {5'h0, i[1:0], 1'b0});
      wr(CTRL_ADDR, 8'h40);
      c = rnd() % 7 + 1;
      c0 = cnt;
      repeat (c) if (i == 2) pulse(); else begin
        @(negedge clk) xin = 0;
        repeat (4) @(negedge clk);
        xin = 1;
        repeat (4) @(negedge clk);
      end
      repeat (6) @(negedge clk);
      chk("source", cnt, c0 + c[15:0]);
    end
    wr(CTRL_ADDR, 8'h00);
    for (i = 0; i < 6; i++) begin
      r = rnd();
      @(negedge clk) {wd, sfr_wr, ev, en} = {8'h00, 1'b1, r[9:0]};
      @(negedge clk) {sfr_wr, ev} = 6'h00;
      #1 chk("flags", rd, {3'b000, r[9:5]});
      chk("ev irq", irq, |(r[9:5] & r[4:0]));
    end
    wr(MODE_ADDR, 8'h05);
    wr(CTRL_ADDR, 8'h40);
    @(negedge clk) t0 = 1;
    for (k = 0; k < 70000 && cnt < 16'hFFF0; k++) @(negedge clk);
    t0 = 0;
    if (cnt < 16'hFFF0) begin
      failures++;
      end_sim();
    end
    repeat (4) @(negedge clk);
    c = 17'h10000 - cnt;
    repeat (c) pulse();
    repeat (4) @(negedge clk);
    chk("wrap", cnt, 16'h0000);
    rdk("ovf", CTRL_ADDR, 8'hC0);
    chk("ovf irq", irq, 1);
    wr(MODE_ADDR, 8'h04);
    chk("ovf off", irq, 0);
    wr(CTRL_ADDR, 8'h40);
    rdk("sw clr", CTRL_ADDR, 8'h40);
    wr(CTRL_ADDR, 8'hC0);
    rdk("sw set", CTRL_ADDR, 8'hC0);
    end_sim();
  end
endmodule
